// *** design/csr_clk_gen.sv ***
// Purpose: glitch-free clock level built from sampled oscillator edges
// Assumes: tick marks one half period of the source
// Notes: output toggles every 2**ratio_log ticks
module csr_clk_gen (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic [csr_pkg::RATIO_W-1:0] ratio_log,
   input wire logic run,
   output logic clk_o,
   output logic rise
);
   import csr_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic hit;

   function automatic logic [CNT_W-1:0] span(input logic [RATIO_W-1:0] l);
      span = CNT_W'((6'h01 << l) - 6'h01);
   endfunction

   assign hit = tick & (cnt == span(ratio_log));
   // stop only from low, so no runt pulse leaves the gate
   assign rise = hit & !clk_o & run;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= hit ? '0 : cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clk_o <= 1'b0;
      end else if (hit && (clk_o || run)) begin
         clk_o <= !clk_o;
      end
   end
endmodule

// *** design/csr_pkg.sv ***
// Purpose: shared constants for clock, sleep and reset control
// Assumes: 125 MHz block clock
// Notes: delay counts derive from times in their own units
package csr_pkg;
   localparam int CLK_MHZ = 125;
   localparam int POR_DELAY_US = 13000;
   // settle and watchdog restart times are plain defaults
   localparam int OSC_SETTLE_US = 200;
   localparam int DOG_DELAY_US = 1000;
   localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
   localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
   localparam int DOG_DELAY_CYC = DOG_DELAY_US * CLK_MHZ;
   localparam int DLY_W = 22;
   localparam int RATIO_W = 3;
   localparam int CNT_W = 5;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BOOT_W = 10;
   localparam logic [BOOT_W-1:0] BOOT_ADDR = 10'h000;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;

   localparam int CTRL_DOG_EN = 0;
   localparam int CTRL_DOG_SLOW = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;

   localparam int STS_WAKE = 0;
   localparam int STS_SLEEP = 1;
   localparam int STS_DOG_OK = 2;
   localparam int STS_POR = 4;
   localparam int STS_BO = 5;
   localparam int STS_DOG = 6;

   localparam int CFG_W = 9;
   localparam int CFG_FAST = 0;
   localparam int CFG_DIV = 1;
   localparam int CFG_LVL = 4;
   localparam int CFG_DOG_ON = 7;
   localparam int CFG_EXT_RST = 8;
   localparam logic [CFG_W-1:0] CFG_RST = 9'h000;
   localparam logic [2:0] LVL_OFF = 3'h0;
   localparam logic [2:0] DIV_MAX_LOG = 3'h5;

   typedef enum logic [5:0] {
      S_HOLD = 6'b000001,
      S_INIT = 6'b000010,
      S_WAIT = 6'b000100,
      S_RUN = 6'b001000,
      S_SLEEP = 6'b010000,
      S_WAKE = 6'b100000
   } csr_state_type;
endpackage

// *** design/csr_top.sv ***
// Purpose: clock select, sleep control and reset sequencing
// Assumes: oscillators and detectors asynchronous, core on clk
// Notes: registers on an AHB-Lite slave, zero wait states
// Functional notes
// (RULE1) main clock: fast rc divided, or slow rc
// (RULE2) slow system clock always from slow rc
// (RULE3) core clock is main clock over two
// (RULE4) watchdog clock always from slow rc
// (RULE5) fast main: slow rc only for watchdog
// (RULE6) reset or wake runs; stop instruction sleeps
// (RULE7) sleep keeps memory, ports, running timers
// (RULE8) listed wake events leave sleep
// (RULE9) interrupt wake leads to service routine
// (RULE10) every reset restores registers, fetch zero
// (RULE11) power and brownout resets restart oscillator
// (RULE12) watchdog reset keeps oscillator, shorter wait
// (RULE13) power-up steps run in fixed order
// (RULE14) brownout trips at configured level
// (RULE15) brownout detector follows sleep and source
// (RULE16) watchdog overflow while running resets
// (RULE17) watchdog overflow in sleep only wakes
// (RULE18) software delays after slow supply rise
// (RULE19) wake flag marks interrupt wake
// (RULE20) sleep flag cleared by stop, set otherwise
// (RULE21) clear and stop both clear watchdog
// (RULE22) enable bit zero disables watchdog
// (RULE23) config latched in reset, glitch-free gating
// (RULE24) overlapping resets use most severe delay
module csr_top #(
   parameter int POR_DLY = csr_pkg::POR_DELAY_CYC,
   parameter int SETTLE_DLY = csr_pkg::OSC_SETTLE_CYC,
   parameter int DOG_DLY = csr_pkg::DOG_DELAY_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [csr_pkg::ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [csr_pkg::DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic [csr_pkg::DATA_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [csr_pkg::CFG_W-1:0] cfg_word,
   input wire logic supply_ok,
   input wire logic brownout_low,
   input wire logic ext_rst_n,
   input wire logic fast_rc_clk,
   input wire logic slow_rc_clk,
   input wire logic stop_instr,
   input wire logic dog_clear_instr,
   input wire logic dog_overflow,
   input wire logic ext_irq,
   input wire logic kbd_irq,
   input wire logic tmr_irq,
   input wire logic tmr_running,
   output logic main_sys_clk,
   output logic core_clk,
   output logic slow_sys_clk,
   output logic dog_clk,
   output logic fast_rc_osc_en,
   output logic slow_rc_osc_en,
   output logic brownout_det_en,
   output logic [2:0] brownout_level_select,
   output logic core_rst_n,
   output logic core_halt,
   output logic [csr_pkg::BOOT_W-1:0] boot_addr,
   output logic dog_cnt_clr,
   output logic isr_go
);
   import csr_pkg::*;

   csr_state_type state, next_state;
   logic [4:0] sync1, sync2;
   logic fast_d, slow_d, fast_edge, slow_edge;
   logic [CFG_W-1:0] cfg;
   logic [1:0] ctrl;
   logic wake_source_flag, sleep_entered_flag, dog_ok;
   logic [2:0] cause;
   logic sev, next_sev, irq_wake;
   logic [DLY_W-1:0] dly;
   logic cfg_fast, dog_run, dog_hit, por_act, bo_trip, ext_act;
   logic severe, wake_req, int_req, main_run, main_tick, main_rise;
   logic st_hold, st_init, st_wait, st_run, st_sleep, st_wake;
   logic n_hold, n_init, n_sleep, n_run;
   logic [RATIO_W-1:0] main_ratio;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_ok, wr_ctrl, wr_sts;
   logic [DATA_W-1:0] rd_val;

   function automatic logic [RATIO_W-1:0] div_log(input logic [2:0] code);
      div_log = (code > DIV_MAX_LOG) ? DIV_MAX_LOG : code;
   endfunction

   // pins and oscillators: two flops before any use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end else begin
         sync1 <= {supply_ok, brownout_low, ext_rst_n, fast_rc_clk,
                   slow_rc_clk};
         sync2 <= sync1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fast_d <= 1'b0;
         slow_d <= 1'b0;
      end else begin
         fast_d <= sync2[1];
         slow_d <= sync2[0];
      end
   end

   // both edges count, one tick per half period
   assign fast_edge = sync2[1] ^ fast_d;
   assign slow_edge = sync2[0] ^ slow_d;

   assign st_hold = (state == S_HOLD);
   assign st_init = (state == S_INIT);
   assign st_wait = (state == S_WAIT);
   assign st_run = (state == S_RUN);
   assign st_sleep = (state == S_SLEEP);
   assign st_wake = (state == S_WAKE);
   assign n_hold = (next_state == S_HOLD);
   assign n_init = (next_state == S_INIT);
   assign n_sleep = (next_state == S_SLEEP);
   assign n_run = (next_state == S_RUN);

   assign cfg_fast = cfg[CFG_FAST];
   assign dog_run = cfg[CFG_DOG_ON] & ctrl[CTRL_DOG_EN]; // RULE22
   assign dog_hit = dog_overflow & dog_run;
   assign por_act = !sync2[4];
   // detector reports supply at or below the chosen level
   assign bo_trip = sync2[3] & brownout_det_en; // RULE14
   assign ext_act = cfg[CFG_EXT_RST] & !sync2[2];
   assign severe = por_act | bo_trip;
   assign int_req = ext_irq | kbd_irq;
   assign wake_req = int_req | (tmr_irq & tmr_running); // RULE8

   always_comb begin
      next_state = state;
      case (state)
         // supply, detector and pin must all be clear to leave
         S_HOLD: next_state = S_INIT; // RULE13
         S_INIT: next_state = S_WAIT;
         S_WAIT: begin
            if (dly == '0) begin
               next_state = S_RUN;
            end
         end
         S_RUN: begin
            if (dog_hit) begin
               next_state = S_HOLD; // RULE16
            end else if (stop_instr) begin
               next_state = S_SLEEP; // RULE6
            end
         end
         S_SLEEP: begin
            if (dog_hit || wake_req) begin
               next_state = S_WAKE; // RULE17
            end
         end
         S_WAKE: begin
            if (dly == '0) begin
               next_state = S_RUN; // RULE6
            end
         end
         default: next_state = S_HOLD;
      endcase
      if (severe || ext_act) begin
         next_state = S_HOLD; // RULE10
      end
   end

   // severity sticks until the core runs again
   always_comb begin
      next_sev = sev;
      if (severe) begin
         next_sev = 1'b1; // RULE24
      end else if (n_run) begin
         next_sev = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= S_HOLD;
         sev <= 1'b1;
      end else begin
         state <= next_state;
         sev <= next_sev;
      end
   end

   // delay is picked once all sources are gone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dly <= '0;
      end else if (st_init) begin
         dly <= sev ? DLY_W'(POR_DLY + SETTLE_DLY)
                : DLY_W'(DOG_DLY); // RULE12
      end else if (st_sleep && next_state == S_WAKE) begin
         dly <= DLY_W'(SETTLE_DLY);
      end else if ((st_wait || st_wake) && dly != '0) begin
         dly <= dly - 1'b1; // RULE11
      end
   end

   // later config changes have no effect until the next reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg <= CFG_RST;
      end else if (st_hold || st_init) begin
         cfg <= cfg_word; // RULE23
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fast_rc_osc_en <= 1'b0;
         slow_rc_osc_en <= 1'b1;
         brownout_det_en <= 1'b0;
         brownout_level_select <= LVL_OFF;
      end else begin
         // off through hold and init after a power or brownout reset
         fast_rc_osc_en <= cfg_fast & !n_sleep
                           & !((n_hold | n_init) & next_sev); // RULE11
         slow_rc_osc_en <= cfg_fast ?
                           (dog_run & ctrl[CTRL_DOG_SLOW]) : 1'b1; // RULE5
         brownout_det_en <= cfg_fast & (cfg[CFG_LVL +: 3] != LVL_OFF)
                            & !n_sleep; // RULE15
         brownout_level_select <= cfg[CFG_LVL +: 3]; // RULE14
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_rst_n <= 1'b0;
         core_halt <= 1'b1;
         boot_addr <= BOOT_ADDR;
         dog_cnt_clr <= 1'b0;
         isr_go <= 1'b0;
      end else begin
         core_rst_n <= !(n_hold | n_init | next_state == S_WAIT); // RULE10
         // halted core leaves memory and port latches untouched
         core_halt <= !n_run; // RULE7
         boot_addr <= BOOT_ADDR; // RULE10
         dog_cnt_clr <= st_run & (stop_instr | dog_clear_instr); // RULE21
         isr_go <= st_wake & n_run & irq_wake; // RULE9
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_wake <= 1'b0;
      end else if (st_sleep && next_state == S_WAKE) begin
         irq_wake <= wake_req;
      end
   end

   // main clock source and ratio
   assign main_tick = cfg_fast ? fast_edge : slow_edge; // RULE1
   assign main_ratio = cfg_fast ? div_log(cfg[CFG_DIV +: 3]) : '0; // RULE1
   assign main_run = (cfg_fast ? fast_rc_osc_en : 1'b1) & !st_sleep;

   csr_clk_gen u_main (
      .clk(clk),
      .nrst(nrst),
      .tick(main_tick),
      .ratio_log(main_ratio),
      .run(main_run),
      .clk_o(main_sys_clk),
      .rise(main_rise)
   );

   // one toggle per main rising edge halves the rate
   csr_clk_gen u_core ( // RULE3
      .clk(clk),
      .nrst(nrst),
      .tick(main_rise),
      .ratio_log(3'h0),
      .run(main_run),
      .clk_o(core_clk),
      .rise()
   );

   csr_clk_gen u_slow ( // RULE2
      .clk(clk),
      .nrst(nrst),
      .tick(slow_edge),
      .ratio_log(3'h0),
      .run(1'b1),
      .clk_o(slow_sys_clk),
      .rise()
   );

   csr_clk_gen u_dog ( // RULE4
      .clk(clk),
      .nrst(nrst),
      .tick(slow_edge),
      .ratio_log(3'h0),
      .run(dog_run),
      .clk_o(dog_clk),
      .rise()
   );

   // ahb-lite slave: reads sampled in the address phase
   assign addr_ok = hsel & hready & htrans[1];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr <= haddr[7:0];
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign wr_ctrl = wr_pend & (wr_addr == OFS_CTRL);
   assign wr_sts = wr_pend & (wr_addr == OFS_STATUS);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CTRL_RST;
      end else if (st_hold) begin
         ctrl <= CTRL_RST; // RULE10
      end else if (wr_ctrl) begin
         ctrl <= hwdata[1:0];
      end
   end

   // hardware set wins over a software write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_source_flag <= 1'b0;
      end else if (st_sleep && next_state == S_WAKE) begin
         wake_source_flag <= int_req; // RULE19
      end else if (por_act) begin
         wake_source_flag <= 1'b0;
      end else if (wr_sts) begin
         wake_source_flag <= hwdata[STS_WAKE];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sleep_entered_flag <= 1'b1;
      end else if (por_act || (st_run && dog_clear_instr)) begin
         sleep_entered_flag <= 1'b1; // RULE20
      end else if (st_run && stop_instr) begin
         sleep_entered_flag <= 1'b0; // RULE20
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dog_ok <= 1'b1;
      end else if (dog_hit) begin
         dog_ok <= 1'b0;
      end else if (por_act || (st_run && (dog_clear_instr || stop_instr))) begin
         dog_ok <= 1'b1;
      end
   end

   // reset cause bits: write one to clear, a new cause wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cause <= 3'h1;
      end else begin
         cause <= (cause & ~(wr_sts ? hwdata[STS_DOG:STS_POR] : 3'h0))
                  | {dog_hit & st_run, bo_trip, por_act};
      end
   end

   always_comb begin
      rd_val = '0;
      case (haddr[7:0])
         OFS_CTRL: rd_val[1:0] = ctrl;
         OFS_STATUS: begin
            rd_val[STS_WAKE] = wake_source_flag;
            rd_val[STS_SLEEP] = sleep_entered_flag;
            rd_val[STS_DOG_OK] = dog_ok;
            rd_val[STS_DOG:STS_POR] = cause;
         end
         OFS_CFG: rd_val[CFG_W-1:0] = cfg;
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= '0;
      end else begin
         hrdata <= (addr_ok && !hwrite) ? rd_val : '0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_init_wait;
      st_init ##1 st_wait;
   endsequence

   sequence s_run_clean;
      !severe && !ext_act && !dog_hit;
   endsequence

   a_core_half_rate: assert property ( // RULE3
      $changed(core_clk) |-> $rose(main_sys_clk))
      else $error("core clock moved without main rising edge");
   a_slow_from_rc: assert property ( // RULE2
      $changed(slow_sys_clk) |-> $past(slow_edge))
      else $error("slow clock moved without slow rc edge");
   a_slow_osc_gate: assert property ( // RULE5
      cfg_fast && !(dog_run && ctrl[CTRL_DOG_SLOW]) |=> !slow_rc_osc_en)
      else $error("slow oscillator on without watchdog need");
   a_stop_sleeps: assert property ( // RULE6
      ((st_run && stop_instr) and s_run_clean) |=>
      st_sleep && core_halt && !fast_rc_osc_en)
      else $error("stop did not enter sleep");
   a_sleep_halted: assert property ( // RULE7
      st_sleep |-> core_halt)
      else $error("core not halted in sleep");
   a_por_wait: assert property ( // RULE11
      s_init_wait |-> !core_rst_n)
      else $error("core released during reset delay");
   a_por_osc_off: assert property ( // RULE11
      st_init && sev |-> !fast_rc_osc_en)
      else $error("oscillator on during power reset init");
   a_dog_keeps_osc: assert property ( // RULE12
      st_hold && !sev && $past(st_run) && cfg_fast |-> fast_rc_osc_en)
      else $error("watchdog reset stopped oscillator");
   a_lvr_sleep_off: assert property ( // RULE15
      st_sleep |-> !brownout_det_en)
      else $error("brownout detector on in sleep");
   a_dog_run_reset: assert property ( // RULE16
      st_run && dog_hit && !severe && !ext_act |=> st_hold ##0 !core_rst_n)
      else $error("watchdog overflow did not reset");
   a_dog_sleep_wake: assert property ( // RULE17
      st_sleep && dog_hit && !severe && !ext_act |=> st_wake && core_rst_n)
      else $error("watchdog in sleep did not just wake");
endmodule

// *** tb/clock_sleep_reset_control_bench.sv ***
// Purpose: self-checking bench for clock, sleep and reset control
// Assumes: short delay parameters, scaled oscillator periods
// Notes: answers sampled one step after each rising edge
module clock_sleep_reset_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import csr_pkg::*;
   localparam int POR = 20;
   localparam int SET = 5;
   localparam int DOG = 10;
   localparam int LONG = POR + SET + 1;
   localparam int SHORT = DOG + 1;
   logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, rdy_q;
   logic [31:0] haddr, hwdata, hrdata, v, hr_q;
   logic [1:0] htrans;
   logic [2:0] hsize, brownout_level_select, lvl;
   logic [CFG_W-1:0] cfg_word, cfg;
   logic supply_ok, brownout_low, ext_rst_n, fast_rc_clk, slow_rc_clk;
   logic stop_instr, dog_clear_instr, dog_overflow, ext_irq, kbd_irq;
   logic tmr_irq, tmr_running, main_sys_clk, core_clk, slow_sys_clk;
   logic dog_clk, fast_rc_osc_en, slow_rc_osc_en, brownout_det_en;
   logic core_rst_n, core_halt, dog_cnt_clr, isr_go;
   logic [BOOT_W-1:0] boot_addr;
   logic [15:0] lfsr;
   int n_fail, n_tests, cm, cc, cs, cd, cf, cl, n_clr, n_isr, n_off;
   int c, c_por, n, k0, k1;
   int dm, dc, ds, dd, df, dl;
   assign hready = hreadyout;
   csr_top #(.POR_DLY(POR), .SETTLE_DLY(SET), .DOG_DLY(DOG)) csr_top_i (
      .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .cfg_word, .supply_ok,
      .brownout_low, .ext_rst_n, .fast_rc_clk, .slow_rc_clk, .stop_instr,
      .dog_clear_instr, .dog_overflow, .ext_irq, .kbd_irq, .tmr_irq,
      .tmr_running, .main_sys_clk, .core_clk, .slow_sys_clk, .dog_clk,
      .fast_rc_osc_en, .slow_rc_osc_en, .brownout_det_en,
      .brownout_level_select, .core_rst_n, .core_halt, .boot_addr,
      .dog_cnt_clr, .isr_go);
   csr_far_model #(.FAST_HALF(32), .SLOW_HALF(200)) csr_far_model_i (
      .fast_rc_osc_en, .slow_rc_osc_en, .fast_rc_clk, .slow_rc_clk);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      hr_q <= hrdata;
      rdy_q <= hready;
      if (dog_cnt_clr === 1'b1)
         n_clr <= n_clr + 1;
      if (isr_go === 1'b1)
         n_isr <= n_isr + 1;
      if (core_rst_n === 1'b0 && fast_rc_osc_en !== 1'b1)
         n_off <= n_off + 1;
   end
   always @(posedge main_sys_clk) cm++;
   always @(posedge core_clk) cc++;
   always @(posedge slow_sys_clk) cs++;
   always @(posedge dog_clk) cd++;
   always @(posedge fast_rc_clk) cf++;
   always @(posedge slow_rc_clk) cl++;
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic near(input int a, input int b);
      return a - b <= 1 && b - a <= 1;
   endfunction
   function automatic logic inr(input int a, input int lo, input int w);
      return a >= lo && a <= lo + w;
   endfunction
   task automatic complete_run;
      if (n_fail == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic rdy;
      int m;
      m = 0;
      do begin
         cyc(1);
         m++;
      end while (rdy_q !== 1'b1 && m < 40);
      if (m >= 40)
         ck(0, 1);
   endtask
   // address phase held until ready, then data phase until ready
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hr_q;
   endtask
   task automatic wait_run(output int m);
      m = 0;
      while (core_rst_n !== 1'b0 && m < 10) begin
         cyc(1);
         m++;
      end
      while (core_rst_n !== 1'b1 && m < 400) begin
         cyc(1);
         m++;
      end
      if (m >= 400)
         ck(0, 1);
   endtask
   // config only taken while reset is held
   task automatic boot(input logic [CFG_W-1:0] f);
      nrst <= 1'b0;
      cfg_word <= f;
      cfg = f;
      cyc(10);
      nrst <= 1'b1;
      wait_run(c);
   endtask
   // counters stay with their edge processes; only differences taken here
   task automatic measure;
      int s[6];
      cyc(4);
      s = '{cm, cc, cs, cd, cf, cl};
      cyc(512);
      dm = cm - s[0];
      dc = cc - s[1];
      ds = cs - s[2];
      dd = cd - s[3];
      df = cf - s[4];
      dl = cl - s[5];
   endtask
   initial begin
      #300000;
      ck(0, 1);
      complete_run();
   end
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      cfg_word = '0;
      supply_ok = 1'b1;
      brownout_low = 1'b0;
      ext_rst_n = 1'b1;
      stop_instr = 1'b0;
      dog_clear_instr = 1'b0;
      dog_overflow = 1'b0;
      ext_irq = 1'b0;
      kbd_irq = 1'b0;
      tmr_irq = 1'b0;
      tmr_running = 1'b0;
      lfsr = 16'h95fc;
      lvl = lfsr[2:0] | 3'h1;
      boot({2'b01, lvl, 3'h0, 1'b1});
      c_por = c;
      ck(inr(c, LONG, 8), 1);
      ck({core_halt, boot_addr}, 0);
      ck(brownout_level_select, lvl);
      bus(0, OFS_CTRL, 0, v);
      ck(v, 32'h3);
      ck({hresp, hreadyout}, 1);
      bus(0, OFS_STATUS, 0, v);
      ck(v, 32'h16);
      cfg_word <= ~cfg;
      bus(0, OFS_CFG, 0, v);
      ck(v, cfg);
      cfg_word <= cfg;
      lfsr = nxt(lfsr);
      bus(1, 8'h0c, {lfsr, ~lfsr}, v);
      bus(0, 8'h0c, 0, v);
      ck(v, 0);
      bus(1, OFS_STATUS, 32'h70, v);
      bus(0, OFS_STATUS, 0, v);
      ck(v, 32'h06);
      for (int i = 0; i < 4; i++) begin
         bus(1, OFS_CTRL, i, v);
         cyc(3);
         ck(slow_rc_osc_en, i == 3);
         bus(0, OFS_CTRL, 0, v);
         ck(v, i);
      end
      bus(1, OFS_CTRL, 2, v);
      dog_overflow <= 1'b1;
      cyc(1);
      dog_overflow <= 1'b0;
      cyc(6);
      ck(core_rst_n, 1);
      bus(1, OFS_CTRL, 1, v);
      k0 = n_off;
      dog_overflow <= 1'b1;
      cyc(1);
      dog_overflow <= 1'b0;
      wait_run(c);
      ck(inr(c, SHORT, 8) && c < c_por, 1);
      ck(n_off - k0, 0);
      bus(0, OFS_STATUS, 0, v);
      ck(v & 32'h44, 32'h40);
      bus(0, OFS_CTRL, 0, v);
      ck(v, 3);
      k0 = n_clr;
      dog_clear_instr <= 1'b1;
      cyc(1);
      dog_clear_instr <= 1'b0;
      cyc(3);
      bus(0, OFS_STATUS, 0, v);
      ck(v & 32'h06, 32'h06);
      ck(n_clr - k0, 1);
      // wake sources: external, keyboard, timer, watchdog
      for (int k = 0; k < 4; k++) begin
         k0 = n_clr;
         k1 = n_isr;
         stop_instr <= 1'b1;
         cyc(1);
         stop_instr <= 1'b0;
         cyc(2);
         ck(core_halt, 1);
         ck({fast_rc_osc_en, brownout_det_en}, 0);
         bus(0, OFS_STATUS, 0, v);
         ck(v[1], 0);
         ck(n_clr - k0, 1);
         if (k == 2) begin
            tmr_irq <= 1'b1;
            cyc(6);
            ck(core_halt, 1);
         end
         case (k)
            0: ext_irq <= 1'b1;
            1: kbd_irq <= 1'b1;
            2: tmr_running <= 1'b1;
            default: dog_overflow <= 1'b1;
         endcase
         cyc(1);
         dog_overflow <= 1'b0;
         n = 0;
         while (core_halt !== 1'b0 && n < 60) begin
            cyc(1);
            n++;
         end
         cyc(2);
         ck(core_rst_n, 1);
         ck({fast_rc_osc_en, brownout_det_en}, 3);
         ck(n_isr - k1, k < 3);
         bus(0, OFS_STATUS, 0, v);
         ck(v[0], k < 2);
         {ext_irq, kbd_irq, tmr_irq, tmr_running} <= 4'h0;
      end
      brownout_low <= 1'b1;
      cyc(4);
      brownout_low <= 1'b0;
      wait_run(c);
      ck(inr(c, LONG, 8), 1);
      bus(0, OFS_STATUS, 0, v);
      ck(v[5], 1);
      // watchdog reset first, then supply loss: the long delay must win
      supply_ok <= 1'b0;
      dog_overflow <= 1'b1;
      cyc(1);
      dog_overflow <= 1'b0;
      cyc(3);
      supply_ok <= 1'b1;
      wait_run(c);
      ck(inr(c, LONG, 8), 1);
      bus(0, OFS_STATUS, 0, v);
      ck(v[4], 1);
      // ratios above five clamp to the slowest divider
      for (int d = 0; d < 7; d++) begin
         boot({2'b01, lvl, d[2:0], 1'b1});
         measure();
         ck(near(dm, df >> (d > 5 ? 5 : d)), 1);
         ck(near(dc, dm / 2), 1);
         ck(near(ds, dl) && near(dd, dl), 1);
      end
      boot({2'b01, lvl, 3'h0, 1'b0});
      measure();
      ck(near(dm, dl) && near(dd, dl), 1);
      ck(near(dc, dm / 2), 1);
      ck(brownout_det_en, 0);
      brownout_low <= 1'b1;
      cyc(6);
      ck(core_rst_n, 1);
      brownout_low <= 1'b0;
      complete_run();
   end
endmodule

// *** tb/csr_far_model.sv ***
// Purpose: on-chip oscillators seen from the control block
// Assumes: periods scaled down so a run stays short
// Notes: a disabled oscillator rests low, no runt edges
module csr_far_model #(
   parameter int FAST_HALF = 32,
   parameter int SLOW_HALF = 200
) (
   input wire logic fast_rc_osc_en,
   input wire logic slow_rc_osc_en,
   output logic fast_rc_clk,
   output logic slow_rc_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      fast_rc_clk = 1'b0;
      forever begin
         #(FAST_HALF);
         // oscillation only while enabled
         fast_rc_clk = (fast_rc_osc_en === 1'b1) ? ~fast_rc_clk
                       : 1'b0;
      end
   end
   initial begin
      slow_rc_clk = 1'b0;
      forever begin
         #(SLOW_HALF);
         slow_rc_clk = (slow_rc_osc_en === 1'b1) ? ~slow_rc_clk
                       : 1'b0;
      end
   end
endmodule
